/* rtl/pec_ctl.sv */
// Purpose: Enables, power-up order, defaults and
//          voltage stepping.
// Assumes: Pins are asynchronous.
// Notes: Avalon-MM registers.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
`include "pec_regs.svh"

// What this block does
// [R01] Ramp rate selectable 1 to 12 mV/us
// [R02] Same ramp rate for rising and falling
// [R03] Higher target approached gradually in regulation
// [R04] Lower target: rectifier sinks output charge
// [R05] Converter voltage programmable 0.8 to 2.4 V
// [R06] Below threshold: high side on, min on-time
// [R07] High side off for min off-time
// [R08] Rectifier on while off, until zero current
// [R09] Soft-start at fixed ramp on enable
// [R10] Enables are pin OR register bit
// [R11] USB switch off only when both set
// [R12] Regulators four, five share one pin
// [R13] Open enable pins low, USB pin high
// [R14] Any enable powers up, registers writable
// [R15] Host clears bits and pins to shut down
// [R16] No enable present: registers to defaults
// [R17] Defaults 1.0, 2.6, 3.3 V; others variant
// [R18] Load switch rise time is programmable
// [R19] Pins rising together power up in order
// [R20] Undervoltage disables outputs, resets registers
// [R21] One code step per rate-derived interval
module pec_ctl
    import pec_pkg::*;
#(
    parameter logic [4:0] REG1_DEF = 5'h14,
    parameter logic [4:0] REG4_DEF = 5'h16,
    parameter logic [4:0] REG5_DEF = 5'h02
)
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic converter_enable_pin,
    input wire logic reg1_enable_pin,
    input wire logic reg2_enable_pin,
    input wire logic reg3_enable_pin,
    input wire logic reg4_reg5_shared_enable_pin,
    input wire logic load_switch_enable_pin,
    input wire logic usb_switch_shutdown_pin,
    input wire logic fb_below_pin,
    input wire logic over_limit_pin,
    input wire logic rect_zero_pin,
    input wire logic uvlo_pin,
    output logic conv_en,
    output logic [6:0] conv_code,
    output logic conv_sink,
    output logic conv_ramping,
    output logic hs_on,
    output logic rect_on,
    output logic reg1_en,
    output logic reg2_en,
    output logic reg3_en,
    output logic reg4_en,
    output logic reg5_en,
    output logic [4:0] reg1_code,
    output logic [4:0] reg2_code,
    output logic [4:0] reg3_code,
    output logic [4:0] reg4_code,
    output logic [4:0] reg5_code,
    output logic ls_en,
    output logic [1:0] ls_rise_sel,
    output logic usb_on,
    output logic dev_active
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Cycles per 25 mV code step at a rate in mV/us.
    function automatic logic [9:0] step_cyc(input logic [3:0] rate);
        logic [15:0] p;
        p = 16'(`PEC_STEP_MV * `PEC_CLK_MHZ) / {12'h000, rate};
        return p[9:0];
    endfunction

    // Clamps a rate to 1..12.
    function automatic logic [3:0] rate_fix(input logic [3:0] v);
        if (v < `PEC_RAMP_MIN) begin
            return `PEC_RAMP_MIN;
        end
        if (v > `PEC_RAMP_MAX) begin
            return `PEC_RAMP_MAX;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [10:0] pin_meta_r, pin_s;
    wire [10:0] pin_raw = {uvlo_pin, rect_zero_pin, over_limit_pin, fb_below_pin,
        usb_switch_shutdown_pin, load_switch_enable_pin, reg4_reg5_shared_enable_pin,
        reg3_enable_pin, reg2_enable_pin, reg1_enable_pin, converter_enable_pin};

    // Reset levels match pulls.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_meta_r <= `PEC_SYNC_RST; // R13
            pin_s <= `PEC_SYNC_RST; // R13
        end else if (ce) begin
            pin_meta_r <= pin_raw;
            pin_s <= pin_meta_r;
        end
    end

    wire uvlo = pin_s[10];
    wire usb_shdn = pin_s[6];
    wire pin45 = pin_s[4];

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [7:0] en_r;
    logic [6:0] cvolt_r;
    logic [3:0] ramp_r;
    logic [1:0] lsrise_r;
    logic [14:0] ldoa_r;
    logic [9:0] ldob_r;
    logic wait_r;
    logic [31:0] rdata_r;

    // One wait state per request.
    wire req = avs_read | avs_write;
    wire wr_go = avs_write & ~wait_r;
    wire wr_en = wr_go & (avs_address == `PEC_OFS_EN);
    wire wr_cv = wr_go & (avs_address == `PEC_OFS_CVOLT);
    wire wr_rr = wr_go & (avs_address == `PEC_OFS_RAMP);
    wire wr_ls = wr_go & (avs_address == `PEC_OFS_LSRISE);
    wire wr_la = wr_go & (avs_address == `PEC_OFS_LDOA);
    wire wr_lb = wr_go & (avs_address == `PEC_OFS_LDOB);

    // Defaults when idle or in UVLO.
    wire present = |pin_s[5:0] | ~usb_shdn | |en_r[6:0];
    wire clr = uvlo | ~present; // R16 R20
    wire [6:0] cv_wd = avs_writedata[6:0];
    wire [6:0] cv_fix = (cv_wd > `PEC_CVOLT_MAX) ? `PEC_CVOLT_MAX : cv_wd; // R05
    wire [14:0] ldoa_def = {`PEC_REG3_RST, `PEC_REG2_RST, REG1_DEF}; // R17
    wire [9:0] ldob_def = {REG5_DEF, REG4_DEF}; // R17
    wire [14:0] la_wd = {avs_writedata[20:16], avs_writedata[12:8], avs_writedata[4:0]};
    wire [9:0] lb_wd = {avs_writedata[12:8], avs_writedata[4:0]};

    // A write beats the clear.
    wire [7:0] en_nxt = wr_en ? avs_writedata[7:0] : clr ? `PEC_EN_RST : en_r; // R14
    wire [6:0] cvolt_nxt = wr_cv ? cv_fix : clr ? `PEC_CVOLT_RST : cvolt_r;
    wire [3:0] ramp_nxt = wr_rr ? rate_fix(avs_writedata[3:0]) // R01
        : clr ? `PEC_RAMP_RST : ramp_r;
    wire [1:0] lsrise_nxt = wr_ls ? avs_writedata[1:0] // R18
        : clr ? `PEC_LSRISE_RST : lsrise_r;
    wire [14:0] ldoa_nxt = wr_la ? la_wd : clr ? ldoa_def : ldoa_r;
    wire [9:0] ldob_nxt = wr_lb ? lb_wd : clr ? ldob_def : ldob_r;

    // Register storage.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            en_r <= `PEC_EN_RST;
            cvolt_r <= `PEC_CVOLT_RST; // R17
            ramp_r <= `PEC_RAMP_RST;
            lsrise_r <= `PEC_LSRISE_RST;
            ldoa_r <= {`PEC_REG3_RST, `PEC_REG2_RST, REG1_DEF};
            ldob_r <= {REG5_DEF, REG4_DEF};
        end else if (ce) begin
            en_r <= en_nxt;
            cvolt_r <= cvolt_nxt;
            ramp_r <= ramp_nxt;
            lsrise_r <= lsrise_nxt;
            ldoa_r <= ldoa_nxt;
            ldob_r <= ldob_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Enable combining and power-up sequencer
    // ------------------------------------------------------------------
    pec_seq_e seq_r;
    logic [2:0] stage_r;
    logic [11:0] seq_cnt_r;
    logic prv_low_r;

    // Raw output requests.
    wire [5:0] req6 = {
        pin45 | en_r[`PEC_EN_REG5], // R12
        pin45 | en_r[`PEC_EN_REG4], // R12
        pin_s[3] | en_r[`PEC_EN_REG3], // R10
        pin_s[2] | en_r[`PEC_EN_REG2], // R10
        pin_s[1] | en_r[`PEC_EN_REG1], // R10
        pin_s[0] | en_r[`PEC_EN_CONV]}; // R10
    wire ls_req = pin_s[5] | en_r[`PEC_EN_LS]; // R10
    wire usb_req = ~(usb_shdn & en_r[`PEC_EN_USB]); // R11

    // All five pins rising starts it.
    wire all5 = &pin_s[4:0];
    wire seq_start = prv_low_r & all5; // R19
    wire seq_run = seq_r == PEC_SEQ_RUN;
    wire seq_tick = seq_cnt_r == 12'(`PEC_SEQ_CYC - 1);
    wire [5:0] seq_mask = seq_run ? ~(6'h3f << stage_r) : seq_start ? 6'h01 : 6'h3f; // R19
    wire [5:0] out6_nxt = req6 & seq_mask & {6{~uvlo}}; // R20

    // One more output per interval.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_r <= PEC_SEQ_IDLE;
            stage_r <= 3'h0;
            seq_cnt_r <= 12'h000;
            prv_low_r <= 1'b0;
        end else if (ce) begin
            prv_low_r <= ~|pin_s[4:0];
            unique case (seq_r)
                PEC_SEQ_IDLE: begin
                    seq_cnt_r <= 12'h000;
                    stage_r <= 3'h1;
                    if (seq_start & ~uvlo) begin
                        seq_r <= PEC_SEQ_RUN; // R19
                    end
                end
                PEC_SEQ_RUN: begin
                    seq_cnt_r <= seq_tick ? 12'h000 : seq_cnt_r + 12'h001;
                    if (seq_tick) begin
                        stage_r <= stage_r + 3'h1; // R19
                    end
                    if (~all5 | uvlo | (seq_tick & stage_r == `PEC_SEQ_STAGES - 3'h1)) begin
                        seq_r <= PEC_SEQ_IDLE;
                    end
                end
                default: begin
                    seq_r <= PEC_SEQ_IDLE;
                end
            endcase
        end
    end

    // Registered enable outputs.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            {reg5_en, reg4_en, reg3_en, reg2_en, reg1_en, conv_en} <= 6'h00;
            ls_en <= 1'b0;
            usb_on <= 1'b0;
            dev_active <= 1'b0;
        end else if (ce) begin
            {reg5_en, reg4_en, reg3_en, reg2_en, reg1_en, conv_en} <= out6_nxt;
            ls_en <= ls_req & ~uvlo;
            usb_on <= usb_req & ~uvlo;
            dev_active <= present & ~uvlo; // R14
        end
    end

    // ------------------------------------------------------------------
    // Converter voltage stepping
    // ------------------------------------------------------------------
    logic [6:0] cur_r;
    logic [9:0] tick_r;
    logic ss_r;
    logic conv_prv_r;

    // Soft-start has a fixed rate.
    wire [9:0] period = step_cyc(ss_r ? `PEC_SS_RATE : ramp_r); // R09 R02
    wire at_tgt = cur_r == cvolt_r;
    wire go_up = cur_r < cvolt_r;
    wire step = tick_r >= period - 10'h001; // R21
    wire sink_nxt = conv_en & ~ss_r & ~go_up & ~at_tgt; // R04

    // One step per interval.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r <= 7'h00;
            tick_r <= 10'h000;
            ss_r <= 1'b0;
            conv_prv_r <= 1'b0;
        end else if (ce) begin
            conv_prv_r <= conv_en;
            if (!conv_en) begin
                cur_r <= 7'h00;
                tick_r <= 10'h000;
                ss_r <= 1'b0;
            end else if (!conv_prv_r) begin
                cur_r <= 7'h00; // R09
                tick_r <= 10'h000;
                ss_r <= 1'b1; // R09
            end else if (at_tgt) begin
                tick_r <= 10'h000; // R21
                ss_r <= 1'b0;
            end else if (step) begin
                tick_r <= 10'h000;
                cur_r <= go_up ? cur_r + 7'h01 : cur_r - 7'h01; // R03 R02 R21
            end else begin
                tick_r <= tick_r + 10'h001;
            end
        end
    end

    // Registered converter and regulator settings.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_code <= 7'h00;
            conv_sink <= 1'b0;
            conv_ramping <= 1'b0;
            ls_rise_sel <= `PEC_LSRISE_RST;
            {reg3_code, reg2_code, reg1_code} <= {`PEC_REG3_RST, `PEC_REG2_RST, REG1_DEF};
            {reg5_code, reg4_code} <= {REG5_DEF, REG4_DEF};
        end else if (ce) begin
            conv_code <= cur_r;
            conv_sink <= sink_nxt; // R04
            conv_ramping <= conv_en & ~at_tgt;
            ls_rise_sel <= lsrise_r; // R18
            {reg3_code, reg2_code, reg1_code} <= ldoa_r;
            {reg5_code, reg4_code} <= ldob_r;
        end
    end

    // Switch timing.
    pec_hyst u_hyst (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ce(ce),
        .enable(conv_en & ~uvlo),
        .below_thr(pin_s[7]),
        .over_limit(pin_s[8]),
        .rect_zero(pin_s[9]),
        .sink_req(conv_sink),
        .hs_on(hs_on),
        .rect_on(rect_on)
    );

    // ------------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------------
    wire [31:0] stat = {13'h0000, dev_active, seq_run, conv_ramping, 1'b0, conv_code,
        usb_on, reg5_en, reg4_en, ls_en, reg3_en, reg2_en, reg1_en, conv_en};
    wire [31:0] rd_mux =
        (avs_address == `PEC_OFS_EN) ? {24'h000000, en_r} :
        (avs_address == `PEC_OFS_CVOLT) ? {25'h0000000, cvolt_r} :
        (avs_address == `PEC_OFS_RAMP) ? {28'h0000000, ramp_r} :
        (avs_address == `PEC_OFS_LSRISE) ? {30'h00000000, lsrise_r} :
        (avs_address == `PEC_OFS_LDOA) ?
            {11'h000, ldoa_r[14:10], 3'h0, ldoa_r[9:5], 3'h0, ldoa_r[4:0]} :
        (avs_address == `PEC_OFS_LDOB) ? {19'h00000, ldob_r[9:5], 3'h0, ldob_r[4:0]} :
        (avs_address == `PEC_OFS_STAT) ? stat : 32'h00000000;

    // Handshake and read data.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wait_r <= 1'b1;
            rdata_r <= 32'h00000000;
        end else if (ce) begin
            wait_r <= ~(req & wait_r);
            if (avs_read & wait_r) begin
                rdata_r <= rd_mux;
            end
        end
    end

    assign avs_waitrequest = wait_r;
    assign avs_readdata = rdata_r;

endmodule // pec_ctl

/* rtl/pec_hyst.sv */
// Purpose: Converter switch timing.
// Assumes: Synced inputs.
// Notes: Outputs are registered.
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_hyst
    import pec_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic enable,
    input wire logic below_thr,
    input wire logic over_limit,
    input wire logic rect_zero,
    input wire logic sink_req,
    output logic hs_on,
    output logic rect_on
);

    pec_sw_e state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic rect_nxt;

    // ------------------------------------------------------------------
    // Phase decisions
    // ------------------------------------------------------------------
    wire cnt_done = cnt_r == 4'h0;
    wire [3:0] cnt_dec = cnt_done ? 4'h0 : cnt_r - 4'h1;
    wire go_high = below_thr;
    wire end_high = over_limit | (cnt_done & ~below_thr);
    wire end_low = cnt_done & below_thr;

    // Next phase and counter.
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_dec;
        rect_nxt = rect_on;
        unique case (state_r)
            PEC_SW_IDLE: begin
                rect_nxt = 1'b0;
                if (go_high) begin
                    state_nxt = PEC_SW_HIGH; // R06
                    cnt_nxt = 4'(`PEC_TON_CYC);
                end
            end
            PEC_SW_HIGH: begin
                rect_nxt = 1'b0;
                if (end_high) begin
                    state_nxt = PEC_SW_LOW; // R06
                    cnt_nxt = 4'(`PEC_TOFF_CYC);
                    rect_nxt = 1'b1; // R08
                end
            end
            PEC_SW_LOW: begin
                if (rect_zero & ~sink_req) begin
                    rect_nxt = 1'b0; // R08 R04
                end
                if (end_low) begin
                    state_nxt = PEC_SW_HIGH; // R07
                    cnt_nxt = 4'(`PEC_TON_CYC);
                    rect_nxt = 1'b0; // R08
                end
            end
            default: begin
                state_nxt = PEC_SW_IDLE;
                rect_nxt = 1'b0;
            end
        endcase
        if (!enable) begin
            state_nxt = PEC_SW_IDLE;
            rect_nxt = 1'b0;
            cnt_nxt = 4'h0;
        end
    end

    // Phase registers.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= PEC_SW_IDLE;
            cnt_r <= 4'h0;
            hs_on <= 1'b0;
            rect_on <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            hs_on <= state_nxt == PEC_SW_HIGH;
            rect_on <= rect_nxt;
        end
    end

endmodule // pec_hyst

/* rtl/pec_pkg.sv */
// Purpose: Shared types.
// Assumes: None.
// Notes: One-hot state codes.
package pec_pkg;

    // Power-up sequencer states.
    typedef enum logic [1:0] {
        PEC_SEQ_IDLE = 2'b01,
        PEC_SEQ_RUN = 2'b10
    } pec_seq_e;

    // Converter switching phases.
    typedef enum logic [2:0] {
        PEC_SW_IDLE = 3'b001,
        PEC_SW_HIGH = 3'b010,
        PEC_SW_LOW = 3'b100
    } pec_sw_e;

endpackage

/* rtl/pec_regs.svh */
// Purpose: Offsets, fields, resets and counts.
// Assumes: 25 MHz mclk.
// Notes: Definitions only.
`ifndef PEC_REGS_SVH
`define PEC_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PEC_OFS_EN 6'h00
`define PEC_OFS_CVOLT 6'h04
`define PEC_OFS_RAMP 6'h08
`define PEC_OFS_LSRISE 6'h0c
`define PEC_OFS_LDOA 6'h10
`define PEC_OFS_LDOB 6'h14
`define PEC_OFS_STAT 6'h18

// ----------------------------------------------------------------------
// Enable bits
// ----------------------------------------------------------------------
`define PEC_EN_CONV 0
`define PEC_EN_REG1 1
`define PEC_EN_REG2 2
`define PEC_EN_REG3 3
`define PEC_EN_LS 4
`define PEC_EN_REG4 5
`define PEC_EN_REG5 6
`define PEC_EN_USB 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PEC_EN_RST 8'h00
`define PEC_CVOLT_RST 7'h08
`define PEC_CVOLT_MAX 7'h40
`define PEC_RAMP_RST 4'h1
`define PEC_RAMP_MIN 4'h1
`define PEC_RAMP_MAX 4'hc
`define PEC_LSRISE_RST 2'h0
`define PEC_REG2_RST 5'h12
`define PEC_REG3_RST 5'h19
`define PEC_SYNC_RST 11'h040

// ----------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------
`define PEC_CLK_MHZ 25
`define PEC_STEP_MV 25
`define PEC_SS_RATE 4'h2
`define PEC_TON_NS 100
`define PEC_TOFF_NS 100
`define PEC_TON_CYC ((`PEC_TON_NS * `PEC_CLK_MHZ + 999) / 1000)
`define PEC_TOFF_CYC ((`PEC_TOFF_NS * `PEC_CLK_MHZ + 999) / 1000)
`define PEC_SEQ_US 100
`define PEC_SEQ_CYC (`PEC_SEQ_US * `PEC_CLK_MHZ)
`define PEC_SEQ_STAGES 3'h6

`endif

/* verif/pec_ctl_monitor.sv */
// Purpose: Port checks for pec_ctl.
// Assumes: One clock.
// Notes: Bound below.
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_ctl_monitor (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic converter_enable_pin,
    input wire logic load_switch_enable_pin,
    input wire logic usb_switch_shutdown_pin,
    input wire logic uvlo_pin,
    input wire logic conv_en,
    input wire logic [6:0] conv_code,
    input wire logic hs_on,
    input wire logic rect_on,
    input wire logic ls_en,
    input wire logic [4:0] reg2_code,
    input wire logic [4:0] reg3_code,
    input wire logic usb_on,
    input wire logic dev_active
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // Port relations.
    a_bus_answer_next: assert property (
        (avs_read || avs_write) && avs_waitrequest && ce ##1 ce |-> !avs_waitrequest)
        else $error("no bus answer");
    a_uvlo_all_off: assert property (
        uvlo_pin [*5] |-> !conv_en && !ls_en && !usb_on && !dev_active)
        else $error("on in uvlo");
    a_conv_pin_or: assert property (
        (converter_enable_pin && !uvlo_pin) [*5] |-> conv_en)
        else $error("conv off");
    a_ls_pin_or: assert property (
        (load_switch_enable_pin && !uvlo_pin) [*5] |-> ls_en)
        else $error("ls off");
    a_usb_nand_on: assert property (
        (!usb_switch_shutdown_pin && !uvlo_pin) [*5] |-> usb_on)
        else $error("usb off");
    a_code_one_step: assert property (
        conv_en && $past(conv_en) && conv_code != $past(conv_code)
        |-> conv_code == $past(conv_code) + 7'h01 || conv_code == $past(conv_code) - 7'h01)
        else $error("code jump");
    a_code_in_range: assert property (conv_code <= `PEC_CVOLT_MAX)
        else $error("code range");
    a_hs_min_off: assert property ($fell(hs_on) |-> !hs_on [*3])
        else $error("off too short");
    a_no_overlap: assert property (!(hs_on && rect_on))
        else $error("overlap");
    a_idle_defaults: assert property (
        !dev_active [*2] |-> reg2_code == `PEC_REG2_RST && reg3_code == `PEC_REG3_RST)
        else $error("not default");
endmodule // pec_ctl_monitor

bind pec_ctl pec_ctl_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .converter_enable_pin(converter_enable_pin), .uvlo_pin(uvlo_pin),
    .load_switch_enable_pin(load_switch_enable_pin), .conv_en(conv_en),
    .usb_switch_shutdown_pin(usb_switch_shutdown_pin), .conv_code(conv_code),
    .hs_on(hs_on), .rect_on(rect_on), .ls_en(ls_en), .reg2_code(reg2_code),
    .reg3_code(reg3_code), .usb_on(usb_on), .dev_active(dev_active));

/* verif/pec_ctl_tb.sv */
// Purpose: Bench for pec_ctl.
// Assumes: 25 MHz mclk, ce held high.
// Notes: Fixed seed.
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_ctl_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic uvlo = 1'b0;
    logic fb = 1'b0, olim = 1'b0, rz = 1'b0;
    logic [5:0] adr;
    logic rd_s, wr_s, wrq;
    logic [31:0] wd, rdd, d;
    logic [6:0] pins, code, p;
    logic [7:0] en, b;
    logic [4:0] r2c;
    logic [1:0] lsr;
    logic sink, act;
    integer seed = 32'h79676c3d;
    int error_cnt = 0, n_checks = 0, cycles = 0, t;

    pec_host host (.mclk(mclk), .avs_waitrequest(wrq), .avs_readdata(rdd),
        .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd),
        .pins(pins));
    pec_ctl dut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1), .avs_address(adr),
        .avs_read(rd_s), .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdd),
        .avs_waitrequest(wrq), .converter_enable_pin(pins[0]),
        .reg1_enable_pin(pins[1]), .reg2_enable_pin(pins[2]), .reg3_enable_pin(pins[3]),
        .load_switch_enable_pin(pins[4]), .reg4_reg5_shared_enable_pin(pins[5]),
        .usb_switch_shutdown_pin(pins[6]), .fb_below_pin(fb), .over_limit_pin(olim),
        .rect_zero_pin(rz), .uvlo_pin(uvlo), .conv_en(en[0]), .conv_code(code),
        .conv_sink(sink), .conv_ramping(), .hs_on(), .rect_on(), .reg1_en(en[1]),
        .reg2_en(en[2]), .reg3_en(en[3]), .reg4_en(en[5]), .reg5_en(en[6]),
        .reg1_code(), .reg2_code(r2c), .reg3_code(), .reg4_code(), .reg5_code(),
        .ls_en(en[4]), .ls_rise_sel(lsr), .usb_on(en[7]), .dev_active(act));

    always #20 mclk = ~mclk;

    // Random comparators; cycle ceiling.
    always @(posedge mclk) begin
        {fb, olim, rz} <= 3'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // Expected enables from pins and bits.
    function automatic logic [7:0] exp_en(input logic [6:0] pv, input logic [7:0] bv);
        exp_en[5:0] = pv[5:0] | bv[5:0];
        exp_en[6] = pv[5] | bv[6];
        exp_en[7] = !(pv[6] & bv[7]);
    endfunction

    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", nm, e, s);
            error_cnt++;
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task rc(input logic [5:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, d);
        chk("read", e, d);
    endtask
    task wr(input logic [5:0] a, input logic [31:0] v);
        host.xfer(1'b1, a, v, d);
    endtask
    // Cycles until code hits target.
    task ramp(input logic [6:0] tgt, input int lo, input int hi);
        t = 0;
        while (code !== tgt && t < 4000) begin
            cyc(1);
            t++;
        end
        chk("ramp time", 32'h1, 32'(t >= lo && t <= hi));
    endtask
    task give_verdict();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rc(`PEC_OFS_CVOLT, 32'h8);
        rc(`PEC_OFS_LDOA, 32'h00191214);
        rc(`PEC_OFS_RAMP, 32'h1);
        wr(6'h1c, 32'hffffffff);
        rc(6'h1c, 32'h0);
        host.set_pins(7'h6f);
        cyc(10);
        chk("seq first", 8'h81, en);
        cyc(2500);
        chk("seq second", 8'h83, en);
        cyc(10000);
        chk("seq last", 8'hef, en);
        for (int i = 0; i < 10; i++) begin
            p = 7'($random(seed)) & 7'h7d;
            b = 8'($random(seed)) | 8'h01;
            wr(`PEC_OFS_EN, 32'(b));
            host.set_pins(p);
            wr(`PEC_OFS_LSRISE, 32'(b[1:0]));
            wr(`PEC_OFS_LDOA, {19'h0, b[4:0], 8'h00});
            cyc(6);
            chk("enables", exp_en(p, b), en);
            chk("ls rise", b[1:0], lsr);
            chk("reg2 code", b[4:0], r2c);
        end
        host.set_pins(7'h40);
        wr(`PEC_OFS_EN, 32'h0);
        cyc(6);
        wr(`PEC_OFS_EN, 32'h1);
        ramp(7'h08, 7 * 312, 8 * 312 + 10);
        wr(`PEC_OFS_RAMP, 32'h0);
        rc(`PEC_OFS_RAMP, 32'h1);
        wr(`PEC_OFS_RAMP, 32'hd);
        rc(`PEC_OFS_RAMP, 32'hc);
        wr(`PEC_OFS_CVOLT, 32'ha);
        ramp(7'h0a, 625 / 12, 2 * (625 / 12) + 4);
        wr(`PEC_OFS_RAMP, 32'h5);
        wr(`PEC_OFS_CVOLT, 32'h7);
        cyc(3);
        chk("sink", 32'h1, 32'(sink));
        ramp(7'h07, 2 * (625 / 5), 3 * (625 / 5) + 4);
        wr(`PEC_OFS_CVOLT, 32'h64);
        rc(`PEC_OFS_CVOLT, 32'h40);
        @(posedge mclk);
        uvlo <= 1'b1;
        cyc(6);
        chk("uvlo outs", 9'h0, {act, en});
        rc(`PEC_OFS_CVOLT, 32'h8);
        rc(`PEC_OFS_STAT, 32'h0);
        uvlo <= 1'b0;
        wr(`PEC_OFS_EN, 32'h1);
        wr(`PEC_OFS_CVOLT, 32'h14);
        host.shut_down();
        cyc(6);
        chk("active", 32'h0, 32'(act));
        rc(`PEC_OFS_CVOLT, 32'h8);
        give_verdict();
    end
endmodule // pec_ctl_tb

/* verif/pec_host.sv */
// Purpose: Host model: pins and bus.
// Assumes: Waitrequest answers.
// Notes: Tasks only.
`timescale 1ns/1ps
`include "pec_regs.svh"

module pec_host (
    input wire logic mclk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [5:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [6:0] pins
);
    // Pins idle at pull levels.
    initial begin
        avs_address = 6'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        pins = 7'h40;
    end

    // One access; released lines show junk.
    task xfer(input logic w, input logic [5:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= wd;
        avs_read <= !w;
        avs_write <= w;
        @(posedge mclk);
        while (avs_waitrequest) @(posedge mclk);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~wd;
    endtask

    // Pins change after an edge.
    task set_pins(input logic [6:0] p);
        @(posedge mclk);
        pins <= p;
    endtask

    // Clear all bits, idle all pins.
    task shut_down();
        logic [31:0] d;
        xfer(1'b1, `PEC_OFS_EN, 32'h0, d);
        pins <= 7'h40;
    endtask
endmodule // pec_host
